/* common/ccdt_consts.vh */
// constants for the ccd digitizer timing and control block
`ifndef CCDT_CONSTS_VH
`define CCDT_CONSTS_VH
// register addresses (4-bit serial address)
`define CCDT_ADDR_GAIN 4'h0
`define CCDT_ADDR_DELAY 4'h2
`define CCDT_ADDR_CLOCK 4'h3
`define CCDT_ADDR_CTRL 4'h4
`define CCDT_ADDR_RESET 4'hf
// sample_phase_delay fields
`define CCDT_DLY_BLK_HI 7
`define CCDT_DLY_BLK_LO 5
`define CCDT_DLY_VID_HI 4
`define CCDT_DLY_VID_LO 2
// clock register fields
`define CCDT_CLK_GATE_EN 6
`define CCDT_CLK_CLAMP_OPT 4
`define CCDT_CLK_CAL_POL 0
`define CCDT_CLK_CLAMP_POL 1
`define CCDT_CLK_BLK_POL 2
`define CCDT_CLK_VID_POL 3
// control register fields
`define CCDT_CTL_OE 0
`define CCDT_CTL_SLEEP 1
`define CCDT_CTL_DIRECT 2
// reset values
`define CCDT_RST_GAIN 8'h00
`define CCDT_RST_DELAY 8'h00
`define CCDT_RST_CLOCK 8'h4c
`define CCDT_RST_CTRL 8'h01
// gain coarse boundaries
`define CCDT_GAIN_B1 8'h40
`define CCDT_GAIN_B2 8'h80
// aperture delays in picoseconds
`define CCDT_BLK_BASE_PS 16'h0dac
`define CCDT_VID_BASE_PS 16'h0a8c
`define CCDT_STEP_PS 16'h07d0
// pipeline latency in pixel cycles
`define CCDT_LATENCY 4
// serial word length and self-clear delay in cycles
`define CCDT_WORD_BITS 12
`define CCDT_RST_HOLD 4'h8
`define CCDT_FULL_CODE 10'h3ff
`endif

/* rtl/ccdt_pipe.v */
// pixel pipeline delay line for converter codes
`timescale 1ns/1ps
`default_nettype none
module ccdt_pipe #(
  parameter WIDTH = 10,
  parameter DEPTH = 4
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // stream
  input wire adv,
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] stage_ff [0:DEPTH-1];
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1)
    begin : g_st
      always @(posedge clk or posedge rst)
      begin
        if (rst)
          stage_ff[i] <= {WIDTH{1'b0}};
        else if (adv)
          stage_ff[i] <= (i == 0) ? din : stage_ff[(i == 0) ? 0 : i - 1];
      end
    end
  endgenerate
  assign dout = stage_ff[DEPTH-1];
endmodule
`default_nettype wire

/* rtl/ccdt_top.v */
// ccd digitizer timing and control: phases, line modes, gain, output bus
`timescale 1ns/1ps
`default_nettype none
`include "ccdt_consts.vh"
module ccdt_top #(
  parameter DW = 10,
  parameter DLY_BITS = 3
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // serial configuration port
  input wire cfg_sclk,
  input wire cfg_load_n,
  input wire serial_config_word,
  // pixel strobes and line signals (pins)
  input wire black_sample_strobe,
  input wire video_sample_strobe,
  input wire cal_window,
  input wire clamp_in,
  input wire sleep_request,
  // converted sample from the analog core
  input wire [DW-1:0] conv_code,
  input wire [DW-1:0] direct_converter_input,
  input wire below_bottom_reference,
  input wire above_top_reference,
  // analog controls
  output reg [DLY_BITS-1:0] black_delay_code,
  output reg [DLY_BITS-1:0] video_delay_code,
  output wire [15:0] black_hold_ps,
  output wire [15:0] video_hold_ps,
  output reg reset_noise_gate,
  output reg dc_clamp,
  output reg cal_gate,
  output reg converter_track_clock,
  output reg [1:0] coarse_gain_stage,
  output reg [7:0] fine_gain_stage,
  output reg [7:0] gain_code,
  output reg direct_mode,
  output reg reference_connect,
  output reg pd_active,
  // pixel output bus
  output reg [DW-1:0] pixel_out_bus,
  output reg [DW-1:0] pixel_out_oe
);
  // ---------------------------------------------------------------
  // pin synchronisers: three stages, change taken when 2 and 3 agree
  // ---------------------------------------------------------------
  localparam NS = 8;
  // chain resets to idle pin levels so no false edge follows reset
  localparam [NS-1:0] PIN_IDLE = 8'h32;
  wire [NS-1:0] pin_raw;
  reg [NS-1:0] s1_ff;
  reg [NS-1:0] s2_ff;
  reg [NS-1:0] s3_ff;
  reg [NS-1:0] pin_ff;
  assign pin_raw = {serial_config_word, sleep_request, clamp_in, cal_window,
                    video_sample_strobe, black_sample_strobe, cfg_load_n, cfg_sclk};
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_ff <= PIN_IDLE;
      s2_ff <= PIN_IDLE;
      s3_ff <= PIN_IDLE;
      pin_ff <= PIN_IDLE;
    end
    else
    begin
      s1_ff <= pin_raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      pin_ff <= (s2_ff & s3_ff) | (~(s2_ff ^ s3_ff) & s2_ff) | (pin_ff & (s2_ff ^ s3_ff));
    end
  end
  wire sclk_s = pin_ff[0];
  wire load_n_s = pin_ff[1];
  wire blk_s = pin_ff[2];
  wire vid_s = pin_ff[3];
  wire cal_s = pin_ff[4];
  wire clamp_s = pin_ff[5];
  wire sleep_pin_s = pin_ff[6];
  wire sdi_s = pin_ff[7];
  // ---------------------------------------------------------------
  // edge detection on filtered pins
  // ---------------------------------------------------------------
  reg sclk_d_ff;
  reg load_d_ff;
  reg vid_d_ff;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sclk_d_ff <= 1'b0;
      load_d_ff <= 1'b1;
      vid_d_ff <= 1'b0;
    end
    else
    begin
      sclk_d_ff <= sclk_s;
      load_d_ff <= load_n_s;
      vid_d_ff <= vid_s;
    end
  end
  wire sclk_rise = sclk_s & ~sclk_d_ff;
  wire load_rise = load_n_s & ~load_d_ff;
  // ---------------------------------------------------------------
  // serial port: 4-bit address then 8-bit data, msb first
  // ---------------------------------------------------------------
  reg [`CCDT_WORD_BITS-1:0] shift_ff;
  reg [3:0] bitcnt_ff;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      shift_ff <= {`CCDT_WORD_BITS{1'b0}};
      bitcnt_ff <= 4'h0;
    end
    else if (load_n_s)
      bitcnt_ff <= 4'h0;
    else if (sclk_rise)
    begin
      shift_ff <= {shift_ff[`CCDT_WORD_BITS-2:0], sdi_s};
      if (bitcnt_ff != 4'hf)
        bitcnt_ff <= bitcnt_ff + 4'h1;
    end
  end
  // only a complete 12-bit word is accepted; short frames are dropped
  wire wr_en = load_rise & (bitcnt_ff == 4'hc);
  wire [3:0] wr_addr = shift_ff[11:8];
  wire [7:0] wr_data = shift_ff[7:0];
  // ---------------------------------------------------------------
  // register file with self-clearing soft reset
  // ---------------------------------------------------------------
  reg [7:0] gain_ff;
  reg [7:0] delay_ff;
  reg [7:0] clock_ff;
  reg [7:0] ctrl_ff;
  reg soft_rst_ff;
  reg [3:0] rst_cnt_ff;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      gain_ff <= `CCDT_RST_GAIN;
      delay_ff <= `CCDT_RST_DELAY;
      clock_ff <= `CCDT_RST_CLOCK;
      ctrl_ff <= `CCDT_RST_CTRL;
      soft_rst_ff <= 1'b0;
      rst_cnt_ff <= 4'h0;
    end
    else if (soft_rst_ff)
    begin
      gain_ff <= `CCDT_RST_GAIN;
      delay_ff <= `CCDT_RST_DELAY;
      clock_ff <= `CCDT_RST_CLOCK;
      ctrl_ff <= `CCDT_RST_CTRL;
      rst_cnt_ff <= rst_cnt_ff + 4'h1;
      if (rst_cnt_ff == `CCDT_RST_HOLD - 4'h1)
        soft_rst_ff <= 1'b0;
    end
    else if (wr_en)
    begin
      // sleep does not touch these registers
      case (wr_addr)
        `CCDT_ADDR_GAIN: gain_ff <= wr_data;
        `CCDT_ADDR_DELAY: delay_ff <= wr_data;
        `CCDT_ADDR_CLOCK: clock_ff <= wr_data;
        `CCDT_ADDR_CTRL: ctrl_ff <= wr_data;
        `CCDT_ADDR_RESET:
        begin
          soft_rst_ff <= wr_data[0];
          rst_cnt_ff <= 4'h0;
        end
        default: ;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // pixel cycle: video strobe going to its active level (set by the video polarity bit) marks a new pixel
  // ---------------------------------------------------------------
  wire vid_pol = clock_ff[`CCDT_CLK_VID_POL];
  wire blk_pol = clock_ff[`CCDT_CLK_BLK_POL];
  wire vid_act = vid_s ~^ vid_pol;
  wire vid_act_d = vid_d_ff ~^ vid_pol;
  wire pix_start = vid_act & ~vid_act_d;
  wire vid_fall = ~vid_act & vid_act_d;
  wire sleep = ctrl_ff[`CCDT_CTL_SLEEP] | sleep_pin_s;
  // configuration snapshot applied once per pixel; video and black polarity and the sleep bit act at once
  reg [7:0] clk_cfg_ff;
  reg [7:0] ctl_cfg_ff;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      black_delay_code <= {DLY_BITS{1'b0}};
      video_delay_code <= {DLY_BITS{1'b0}};
      clk_cfg_ff <= `CCDT_RST_CLOCK;
      ctl_cfg_ff <= `CCDT_RST_CTRL;
      gain_code <= 8'h00;
    end
    else if (pix_start)
    begin
      black_delay_code <= delay_ff[`CCDT_DLY_BLK_HI:`CCDT_DLY_BLK_LO];
      video_delay_code <= delay_ff[`CCDT_DLY_VID_HI:`CCDT_DLY_VID_LO];
      clk_cfg_ff <= clock_ff;
      ctl_cfg_ff <= ctrl_ff;
      gain_code <= gain_ff;
    end
  end
  assign black_hold_ps = `CCDT_BLK_BASE_PS +
                         `CCDT_STEP_PS * {{(16-DLY_BITS){1'b0}}, black_delay_code};
  assign video_hold_ps = `CCDT_VID_BASE_PS +
                         `CCDT_STEP_PS * {{(16-DLY_BITS){1'b0}}, video_delay_code};
  // ---------------------------------------------------------------
  // line timing: window, clamp, preblank, reset-noise gate
  // ---------------------------------------------------------------
  wire clamp_opt = clk_cfg_ff[`CCDT_CLK_CLAMP_OPT];
  wire cal_act = cal_s ~^ clk_cfg_ff[`CCDT_CLK_CAL_POL];
  wire clamp_act = clamp_s ~^ clk_cfg_ff[`CCDT_CLK_CLAMP_POL];
  wire blk_act = blk_s ~^ blk_pol;
  // window and clamp never overlap by contract, so no arbitration is done
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dc_clamp <= 1'b0;
      cal_gate <= 1'b0;
      reset_noise_gate <= 1'b0;
    end
    else
    begin
      if (clamp_opt)
        dc_clamp <= clamp_act & vid_act;
      else
        dc_clamp <= cal_act & vid_act;
      cal_gate <= cal_act & ~sleep;
      // gate opens between video and black sampling, or under preblank
      if (~clk_cfg_ff[`CCDT_CLK_GATE_EN])
        reset_noise_gate <= 1'b0;
      else if (~clamp_opt & clamp_act)
        reset_noise_gate <= 1'b1;
      else
        reset_noise_gate <= ~vid_act & ~blk_act;
    end
  end
  // ---------------------------------------------------------------
  // gain decode
  // ---------------------------------------------------------------
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      coarse_gain_stage <= 2'h0;
      fine_gain_stage <= 8'h00;
    end
    else
    begin
      // coarse steps of 8dB, fine takes the remainder in 0.125dB units
      if (gain_code >= `CCDT_GAIN_B2)
        coarse_gain_stage <= 2'h2;
      else if (gain_code >= `CCDT_GAIN_B1)
        coarse_gain_stage <= 2'h1;
      else
        coarse_gain_stage <= 2'h0;
      fine_gain_stage <= (gain_code >= `CCDT_GAIN_B2) ? gain_code - `CCDT_GAIN_B2 :
                         (gain_code >= `CCDT_GAIN_B1) ? gain_code - `CCDT_GAIN_B1 :
                         gain_code;
    end
  end
  // ---------------------------------------------------------------
  // converter clock, direct mode, pipeline and output bus
  // ---------------------------------------------------------------
  wire direct = ctl_cfg_ff[`CCDT_CTL_DIRECT] & ~clamp_opt;
  reg [DW-1:0] sample_code;
  always @*
  begin
    if (direct & below_bottom_reference)
      sample_code = {DW{1'b0}};
    else if (direct & above_top_reference)
      sample_code = `CCDT_FULL_CODE;
    else if (direct)
      sample_code = direct_converter_input;
    else
      sample_code = conv_code;
  end
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      converter_track_clock <= 1'b0;
      direct_mode <= 1'b0;
      reference_connect <= 1'b0;
      pd_active <= 1'b0;
    end
    else
    begin
      // track while video phase inactive, hold while sampling
      converter_track_clock <= ~vid_act & ~sleep;
      direct_mode <= direct;
      reference_connect <= ~sleep;
      pd_active <= sleep;
    end
  end
  wire [DW-1:0] piped;
  // stages advance on the video fall; the analog half cycle makes 3.5 then 4.5 total
  ccdt_pipe #(
    .WIDTH(DW),
    .DEPTH(`CCDT_LATENCY)
  ) u_pipe (
    .clk(clk),
    .rst(rst),
    .adv(vid_fall & ~sleep),
    .din(sample_code),
    .dout(piped)
  );
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pixel_out_bus <= {DW{1'b0}};
      pixel_out_oe <= {DW{1'b0}};
    end
    else
    begin
      if (vid_fall & ~sleep)
        pixel_out_bus <= piped;
      pixel_out_oe <= {DW{ctl_cfg_ff[`CCDT_CTL_OE] & ~sleep}};
    end
  end
endmodule
`default_nettype wire

/* bench/ccdt_tg_model.sv */
// timing generator model: pixel strobes, line signals and serial writes
`timescale 1ns/1ps
`default_nettype none
module ccdt_tg_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pixel strobes
  output logic black_sample_strobe,
  output logic video_sample_strobe,
  // line signals
  output logic cal_window,
  output logic clamp_in,
  // serial port
  output logic cfg_sclk,
  output logic cfg_load_n,
  output logic serial_config_word
);
  logic [3:0] ph_ff;
  logic frame_ff;
  // ------------------------------------------------------------
  // strobes never pause: config snapshots and direct mode need edges
  // ------------------------------------------------------------
  initial
  begin
    {cfg_sclk, serial_config_word, frame_ff} = 3'h0;
    {cfg_load_n, cal_window, clamp_in} = 3'h7;
  end
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      ph_ff <= 4'h0;
    else
      ph_ff <= ph_ff + 4'h1;
  end
  assign video_sample_strobe = ~ph_ff[3];
  assign black_sample_strobe = ph_ff[3];
  // released data line flips every cycle so a stale bit is never read as valid
  always @(posedge clk)
  begin
    if (!frame_ff)
      serial_config_word <= ~serial_config_word;
  end
  // lines are moved together so window and clamp never overlap when active
  task automatic set_lines(input logic win_lvl, input logic clamp_lvl);
    @(posedge clk);
    cal_window <= win_lvl;
    clamp_in <= clamp_lvl;
  endtask
  task automatic write_reg(input logic [3:0] addr, input logic [7:0] data);
    logic [11:0] word;
    word = {addr, data};
    @(posedge clk);
    frame_ff <= 1'h1;
    @(posedge clk);
    cfg_load_n <= 1'h0;
    for (int i = 11; i >= 0; i--)
    begin
      serial_config_word <= word[i];
      repeat (4) @(posedge clk);
      cfg_sclk <= 1'h1;
      repeat (4) @(posedge clk);
      cfg_sclk <= 1'h0;
    end
    repeat (4) @(posedge clk);
    cfg_load_n <= 1'h1;
    repeat (4) @(posedge clk);
    frame_ff <= 1'h0;
  endtask
endmodule
`default_nettype wire

/* bench/ccdt_top_monitor.sv */
// checker: port-level properties of the digitizer control block
`timescale 1ns/1ps
`default_nettype none
module ccdt_top_monitor #(
  parameter DW = 10,
  parameter DLY_BITS = 3
) (
  // clock, reset and watched input
  input wire logic clk,
  input wire logic rst,
  input wire logic sleep_request,
  // watched outputs
  input wire logic [DLY_BITS-1:0] black_delay_code,
  input wire logic [DLY_BITS-1:0] video_delay_code,
  input wire logic [15:0] black_hold_ps,
  input wire logic [15:0] video_hold_ps,
  input wire logic [1:0] coarse_gain_stage,
  input wire logic [7:0] gain_code,
  input wire logic reference_connect,
  input wire logic pd_active,
  input wire logic [DW-1:0] pixel_out_oe
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_blk_hold; black_hold_ps == 16'h0dac + 16'h07d0 * black_delay_code; endproperty
  a_blk_hold: assert property (p_blk_hold) else $error("black hold delay wrong");
  property p_vid_hold; video_hold_ps == 16'h0a8c + 16'h07d0 * video_delay_code; endproperty
  a_vid_hold: assert property (p_vid_hold) else $error("video hold delay wrong");
  property p_oe_even; pixel_out_oe == {DW{1'h0}} || pixel_out_oe == {DW{1'h1}}; endproperty
  a_oe_even: assert property (p_oe_even) else $error("bus enables split");
  property p_sleep_float; $rose(pd_active) |-> ##[0:40] pixel_out_oe == {DW{1'h0}}; endproperty
  a_sleep_float: assert property (p_sleep_float) else $error("bus driven in sleep");
  property p_sleep_ref; pd_active && $past(pd_active) |-> !reference_connect; endproperty
  a_sleep_ref: assert property (p_sleep_ref) else $error("reference kept in sleep");
  property p_sleep_pin; sleep_request [*6] |-> pd_active; endproperty
  a_sleep_pin: assert property (p_sleep_pin) else $error("sleep pin ignored");
  property p_coarse; $stable(gain_code) |-> coarse_gain_stage ==
    (gain_code >= 8'h80 ? 2'h2 : gain_code >= 8'h40 ? 2'h1 : 2'h0); endproperty
  a_coarse: assert property (p_coarse) else $error("coarse stage wrong");
  property p_rst_zero; disable iff (1'h0) rst ##1 rst |-> pixel_out_oe == {DW{1'h0}} &&
    gain_code == 8'h00 && !pd_active; endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("outputs not cleared");
endmodule
bind ccdt_top ccdt_top_monitor #(.DW(DW), .DLY_BITS(DLY_BITS)) mon_u (.clk, .rst,
  .sleep_request, .black_delay_code, .video_delay_code, .black_hold_ps, .video_hold_ps,
  .coarse_gain_stage, .gain_code, .reference_connect, .pd_active, .pixel_out_oe);
`default_nettype wire

/* bench/ccdt_top_bench.sv */
// bench: drives the digitizer control block and checks its outputs
`timescale 1ns/1ps
`default_nettype none
module ccdt_top_bench;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic sleep_request = 1'h0;
  logic below = 1'h0;
  logic above = 1'h0;
  logic [9:0] conv_code = 10'h000;
  logic [9:0] dir_in = 10'h000;
  logic blk_s, vid_s, win, clmp, sclk, ld_n, cfg_d, rng, dcc, calg, dmo, refc, pda;
  logic vid_d, vid_m, ctc;
  logic dmode = 1'h0;
  logic [2:0] bdc, vdc;
  logic [15:0] vps, bps;
  logic [1:0] cgs;
  logic [7:0] gc, fgs;
  logic [9:0] bus, oe;
  logic [10:0] exp_q[$];
  logic [10:0] e;
  logic [31:0] r = 32'h7f35;
  logic [7:0] gtab[7] = '{8'h00, 8'h3f, 8'h40, 8'h7f, 8'h80, 8'hff, 8'h5a};
  logic [11:0] ltab[6] = '{12'h4c7, 12'h5c5, 12'h5ca, 12'h5f9, 12'h5f6, 12'h4c8};
  int num_errors = 0;
  int checks_done = 0;
  int pix = 0;
  int quiet = 8;
  ccdt_tg_model tg_u (.clk(clk), .rst(rst), .black_sample_strobe(blk_s),
    .video_sample_strobe(vid_s), .cal_window(win), .clamp_in(clmp), .cfg_sclk(sclk),
    .cfg_load_n(ld_n), .serial_config_word(cfg_d));
  ccdt_top dut_u (.clk(clk), .rst(rst), .cfg_sclk(sclk), .cfg_load_n(ld_n),
    .serial_config_word(cfg_d), .black_sample_strobe(blk_s), .video_sample_strobe(vid_s),
    .cal_window(win), .clamp_in(clmp), .sleep_request(sleep_request), .conv_code(conv_code),
    .direct_converter_input(dir_in), .below_bottom_reference(below),
    .above_top_reference(above), .black_delay_code(bdc), .video_delay_code(vdc),
    .black_hold_ps(bps), .video_hold_ps(vps), .reset_noise_gate(rng), .dc_clamp(dcc),
    .cal_gate(calg), .converter_track_clock(ctc), .coarse_gain_stage(cgs),
    .fine_gain_stage(fgs), .gain_code(gc), .direct_mode(dmo), .reference_connect(refc),
    .pd_active(pda), .pixel_out_bus(bus), .pixel_out_oe(oe));
  // ------------------------------------------------------------
  // helpers, pixel driver and bus monitor
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_pix(input int n);
    repeat (n * 16) @(posedge clk);
  endtask
  // bus checks pause across control writes and the sleep pin pulse: direct and sleep reshape the data path
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    if (a == 4'h4)
      quiet = 1 << 30;
    tg_u.write_reg(a, d);
    if (a == 4'h4)
      quiet = pix + 8;
    wait_pix(2);
  endtask
  always #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    vid_d <= vid_s;
    if (vid_s && !vid_d)
    begin
      r = lfsr(r);
      conv_code <= r[9:0];
      dir_in <= r[25:16];
      below <= r[12:10] == 3'h7;
      above <= r[12:10] == 3'h6;
      exp_q.push_back({pix >= quiet, !dmode ? r[9:0] : r[12:10] == 3'h7 ? 10'h000 :
        r[12:10] == 3'h6 ? 10'h3ff : r[25:16]});
      pix <= pix + 1;
    end
  end
  always @(negedge clk)
  begin
    vid_m <= vid_s;
    if (vid_s && !vid_m && exp_q.size() > 4)
    begin
      e = exp_q.pop_front();
      if (e[10] && pix >= quiet)
        check(bus, e[9:0]);
    end
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    wait_pix(3);
    check({bdc, vdc, gc, oe, dmo, pda}, {14'h0000, 10'h3ff, 2'h0});
    for (int i = 0; i < 8; i++)
    begin
      wr(4'h2, {i[2:0], 3'h7 - i[2:0], 2'h0});
      check({bdc, vdc}, {i[2:0], 3'h7 - i[2:0]});
      check(vps, 32'h0a8c + 32'h07d0 * (7 - i));
      check(bps, 32'h0dac + 32'h07d0 * i);
    end
    $display("test delays done");
    gtab[6] = r[7:0];
    foreach (gtab[k])
    begin
      wr(4'h0, gtab[k]);
      check({cgs, gc}, {gtab[k] >= 8'h80 ? 2'h2 : gtab[k] >= 8'h40 ? 2'h1 : 2'h0,
        gtab[k]});
      check(fgs, gtab[k] >= 8'h80 ? gtab[k] - 8'h80 : {2'h0, gtab[k][5:0]});
    end
    $display("test gain done");
    foreach (ltab[k])
    begin
      wr(4'h3, ltab[k][11:4]);
      tg_u.set_lines(ltab[k][3], ltab[k][2]);
      wait_pix(1);
      for (int t = 0; t < 20 && tg_u.ph_ff != 4'h6; t++) @(posedge clk);
      if (tg_u.ph_ff != 4'h6)
        num_errors++;
      #1;
      check({dcc, calg}, ltab[k][1:0]);
    end
    check(rng, 1'h1);
    tg_u.set_lines(1'h1, 1'h1);
    wr(4'h3, 8'h0c);
    repeat (16)
    begin
      @(posedge clk);
      check(rng, 1'h0);
    end
    wr(4'h3, 8'h4c);
    $display("test line modes done");
    wr(4'h4, 8'h00);
    wait_pix(10);
    check(oe, 10'h000);
    wr(4'h4, 8'h03);
    check({pda, refc, ctc, oe}, {3'h4, 10'h000});
    wr(4'h4, 8'h01);
    check({pda, refc, gc, oe}, {2'h1, gtab[6], 10'h3ff});
    quiet = 1 << 30;
    sleep_request <= 1'h1;
    wait_pix(1);
    check(pda, 1'h1);
    sleep_request <= 1'h0;
    quiet = pix + 8;
    $display("test enable and sleep done");
    wr(4'h4, 8'h05);
    dmode = 1'h1;
    wait_pix(20);
    check(dmo, 1'h1);
    wr(4'h4, 8'h01);
    dmode = 1'h0;
    wait_pix(10);
    $display("test direct mode done");
    wr(4'h0, 8'h77);
    wr(4'hf, 8'h01);
    check({bdc, vdc, gc, oe}, {14'h0000, 10'h3ff});
    wr(4'h0, 8'h12);
    check(gc, 8'h12);
    $display("test soft reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
